//--- rt_cfg_asserts.sv
// concurrent checks on the link between the host bridge and the terminal
`timescale 1ns/100ps
module rt_cfg_asserts
   import rt_cfg_pkg::*;
(
   // watched link signals
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        host_init_hold,
   input wire logic        app_req,
   input wire logic        app_wr,
   input wire logic [1:0]  app_addr,
   input wire logic [1:0]  app_be,
   input wire logic [15:0] app_wdata,
   input wire logic        app_ack,
   input wire rt_mode_t    dev_mode,
   input wire logic        dev_bcast_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_ACK_DUE: assert property (app_req && !app_ack && dev_mode != ST_RESET |=> app_ack)
      else $error("ack late");
   AST_ACK_ONE: assert property (app_ack |=> !app_ack && !app_req)
      else $error("ack or request held");
   AST_ACK_CAUSE: assert property (app_ack |-> $past(app_req) && $past(dev_mode) != ST_RESET)
      else $error("ack without request");
   AST_REQ_HOLD: assert property (app_req && !app_ack |=> app_req)
      else $error("request dropped early");
   AST_LEAVE_RESET: assert property (rst_n && dev_mode == ST_RESET |=> dev_mode != ST_RESET)
      else $error("stuck in reset state");
   AST_HOLD_INIT: assert property (host_init_hold && dev_mode != ST_RESET |=> dev_mode == ST_INIT)
      else $error("init hold ignored");
   AST_RUN: assert property (!host_init_hold && dev_mode != ST_RESET |=> dev_mode == ST_OPER)
      else $error("not operational");
   AST_BCAST_WR: assert property (app_ack && app_wr && app_addr == MODE_IDX && app_be[0]
      |-> ##[0:2] dev_bcast_en == app_wdata[BCAST_FIELD]) else $error("broadcast field ignored");
   // main scenarios reached
   cover property (dev_mode == ST_INIT ##1 dev_mode == ST_OPER);
   cover property (app_ack && app_wr && app_addr == MODE_IDX);
   cover property (app_ack && !app_wr);
endmodule

//--- rt_cfg_device.sv
// terminal end: operating states, strap capture, command gating and config registers
`timescale 1ns/100ps
module rt_cfg_device
   import rt_cfg_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // host link
   rt_cfg_if.device         link,
   // strap pins
   input  wire logic [2:0]  clock_rate_select,
   input  wire logic [4:0]  terminal_address,
   input  wire logic        terminal_address_parity,
   input  wire logic        broadcast_allow_pin,
   input  wire logic        timeout_select,
   input  wire logic        loop_inhibit_n,
   input  wire logic        encoder_inhibit_n,
   input  wire logic        failsafe_test_select,
   input  wire logic        bus_config_load_enable,
   input  wire logic        scan_test_select,
   // decoded serial traffic from the protocol engine
   input  wire logic        cmd_valid,
   input  wire logic [4:0]  cmd_address,
   input  wire logic [4:0]  cmd_subaddr,
   input  wire logic        cmd_transmit,
   input  wire logic        data_valid,
   input  wire logic [5:0]  data_index,
   input  wire logic [15:0] data_word,
   input  wire logic        msg_end,
   input  wire logic        msg_good,
   // gating results
   output logic             serial_enable,
   output logic             cmd_accept,
   output logic             cmd_reject,
   output logic             broadcast_enable,
   // captured configuration
   output logic             failsafe_test,
   output logic             loop_off_n,
   output logic             encoder_off_n,
   output logic             scan_test,
   output logic [15:0]      reply_timeout_cycles,
   output logic [15:0]      failsafe_cycles,
   // register contents
   output logic [15:0]      terminal_mode_config,
   output logic [15:0]      clock_frame_config,
   output logic [15:0]      interrupt_mask_config,
   output logic [15:0]      host_interface_config
);
   // ----------------------------------------------------------------
   // strap synchroniser
   // ----------------------------------------------------------------
   localparam int SW = 16; // 3 rate + 5 address + 8 single straps
   logic [SW-1:0] strap_lv; // settled strap levels

   strap_sync #(.W(SW)) u_sync (
      .clk   (clk),
      .pin   ({clock_rate_select, terminal_address, terminal_address_parity,
               broadcast_allow_pin, timeout_select, loop_inhibit_n,
               encoder_inhibit_n, failsafe_test_select, bus_config_load_enable,
               scan_test_select}),
      .level (strap_lv)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   rt_mode_t    mode_q, mode_d;             // operating state
   logic [SW-1:0] strap_q, strap_d;         // straps frozen at release
   logic [15:0] regs_q [4];                 // configuration registers
   logic [15:0] regs_d [4];
   logic [15:0] shadow_q [3];               // words 17..19 of current message
   logic [15:0] shadow_d [3];
   logic [2:0]  seen_q, seen_d;             // which shadow words arrived
   logic        load_msg_q, load_msg_d;     // current message is rx to subaddress 1
   logic        written_q, written_d;       // mode register written since reset
   logic        ack_q, ack_d;               // host answer
   logic [15:0] rdata_q, rdata_d;           // host read data
   logic        accept_q, accept_d;         // command taken
   logic        reject_q, reject_d;         // command refused
   logic [15:0] reply_q, reply_d;           // reply timeout in cycles
   logic [15:0] fs_q, fs_d;                 // fail-safe timeout in cycles
   logic        bcast_q, bcast_d;           // broadcast allowed

   // strap fields out of the frozen vector
   logic [2:0]  s_rate;
   logic [4:0]  s_addr;
   logic        s_par, s_broadcast_allow_pin, s_tmo, s_loop, s_enc, s_fs, s_load, s_scan;
   assign {s_rate, s_addr, s_par, s_broadcast_allow_pin, s_tmo, s_loop, s_enc, s_fs, s_load, s_scan}
      = strap_q;

   // merge host bytes into a register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [1:0] be);
      merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic parity_ok;
      logic addr_hit;
      logic host_write;
      parity_ok  = 1'b0;
      addr_hit   = 1'b0;
      host_write = 1'b0;
      mode_d     = mode_q;
      strap_d    = strap_q;
      regs_d     = regs_q;
      shadow_d   = shadow_q;
      seen_d     = seen_q;
      load_msg_d = load_msg_q;
      written_d  = written_q;
      ack_d      = 1'b0;
      rdata_d    = rdata_q;
      accept_d   = 1'b0;
      reject_d   = 1'b0;
      reply_d    = reply_q;
      fs_d       = fs_q;

      // operating state transitions
      case (mode_q)
         ST_RESET: begin // first edge after release: freeze straps
            strap_d = strap_lv;
            mode_d  = link.host_init_hold ? ST_INIT : ST_OPER;
         end
         ST_INIT: begin
            if (!link.host_init_hold) begin
               mode_d = ST_OPER;
            end
         end
         ST_OPER: begin
            if (link.host_init_hold) begin
               mode_d = ST_INIT;
            end
         end
         default: begin
            mode_d = ST_RESET;
         end
      endcase

      // timeouts follow the frozen rate code
      reply_d = us_to_cycles(s_tmo ? REPLY_SHORT_US : REPLY_LONG_US, s_rate);
      fs_d    = us_to_cycles(FAILSAFE_US, s_rate);

      // host access, answered in init and operational only
      if (link.app_req && !ack_q && mode_q != ST_RESET) begin
         ack_d   = 1'b1;
         rdata_d = regs_q[link.app_addr];
         if (link.app_wr) begin
            host_write = 1'b1;
            regs_d[link.app_addr] = merge(regs_q[link.app_addr], link.app_wdata,
                                          link.app_be);
            if (link.app_addr == MODE_IDX) begin
               written_d = 1'b1;
            end
         end
      end

      // command gating, serial side frozen outside operational
      if (cmd_valid && mode_q == ST_OPER) begin
         parity_ok = ^{s_par, s_addr};
         addr_hit  = (cmd_address == s_addr) || (cmd_address == BCAST_ADDR && bcast_q);
         if (addr_hit && parity_ok) begin
            accept_d   = 1'b1;
            seen_d     = 3'h0;
            load_msg_d = !cmd_transmit && cmd_subaddr == LOAD_SUBADDR;
         end else begin
            reject_d   = 1'b1;
         end
      end

      // capture words 17..19 as they arrive, commit later; words still pass on
      if (data_valid && load_msg_q && mode_q == ST_OPER) begin
         for (int i = 0; i < 3; i++) begin
            if (data_index == FIRST_LOAD_WORD + 6'(i)) begin
               shadow_d[i] = data_word;
               seen_d[i]   = 1'b1;
            end
         end
      end

      // commit at descriptor write; only words reached are loaded
      if (msg_end && msg_good && load_msg_q && s_load && mode_q == ST_OPER) begin
         for (int i = 0; i < 3; i++) begin
            if (seen_q[i]) begin
               regs_d[i] = shadow_q[i];
            end
         end
         if (seen_q[0]) begin
            written_d = 1'b1;
         end
      end
      if (msg_end) begin
         load_msg_d = 1'b0;
      end

      // broadcast priority: pin until mode register written
      bcast_d = written_d ? regs_d[MODE_IDX][BCAST_FIELD] : s_broadcast_allow_pin;

      // host writes a register that a load also targets: host wins
      if (host_write) begin
         regs_d[link.app_addr] = merge(regs_q[link.app_addr], link.app_wdata, link.app_be);
         bcast_d = written_d ? regs_d[MODE_IDX][BCAST_FIELD] : s_broadcast_allow_pin;
      end
   end

   // ----------------------------------------------------------------
   // registers, synchronous reset returns every flop to its reset value, config registers to MODE_RST..HOSTIF_RST
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_q     <= ST_RESET;
         strap_q    <= '0;
         regs_q[MODE_IDX]   <= MODE_RST;
         regs_q[CLOCK_IDX]  <= CLOCK_RST;
         regs_q[IMASK_IDX]  <= IMASK_RST;
         regs_q[HOSTIF_IDX] <= HOSTIF_RST;
         for (int i = 0; i < 3; i++) begin
            shadow_q[i] <= '0;
         end
         seen_q     <= '0;
         load_msg_q <= 1'b0;
         written_q  <= 1'b0;
         ack_q      <= 1'b0;
         rdata_q    <= '0;
         accept_q   <= 1'b0;
         reject_q   <= 1'b0;
         reply_q    <= '0;
         fs_q       <= '0;
         bcast_q    <= 1'b0;
      end else begin
         mode_q     <= mode_d;
         strap_q    <= strap_d;
         regs_q     <= regs_d;
         shadow_q   <= shadow_d;
         seen_q     <= seen_d;
         load_msg_q <= load_msg_d;
         written_q  <= written_d;
         ack_q      <= ack_d;
         rdata_q    <= rdata_d;
         accept_q   <= accept_d;
         reject_q   <= reject_d;
         reply_q    <= reply_d;
         fs_q       <= fs_d;
         bcast_q    <= bcast_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flops except serial_enable, decoded from mode_q
   // ----------------------------------------------------------------
   assign link.app_ack          = ack_q;
   assign link.app_rdata        = rdata_q;
   assign link.dev_mode         = mode_q;
   assign link.dev_bcast_en     = bcast_q;
   assign serial_enable         = (mode_q == ST_OPER);
   assign cmd_accept            = accept_q;
   assign cmd_reject            = reject_q;
   assign broadcast_enable      = bcast_q;
   assign failsafe_test         = s_fs;
   assign loop_off_n            = s_loop;
   assign encoder_off_n         = s_enc;
   assign scan_test             = s_scan;
   assign reply_timeout_cycles  = reply_q;
   assign failsafe_cycles       = fs_q;
   assign terminal_mode_config  = regs_q[MODE_IDX];
   assign clock_frame_config    = regs_q[CLOCK_IDX];
   assign interrupt_mask_config = regs_q[IMASK_IDX];
   assign host_interface_config = regs_q[HOSTIF_IDX];
endmodule

//--- rt_cfg_host.sv
// host end: avalon-mm slave with init control, status and a window onto the config registers
`timescale 1ns/100ps
module rt_cfg_host
   import rt_cfg_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // terminal link
   rt_cfg_if.host           link
);
   host_state_t st_q, st_d;       // bus sequencer
   logic        hold_q, hold_d;   // host_init_hold control bit
   logic        req_q, req_d;     // request toward terminal
   logic        wr_q, wr_d;       // its direction
   logic [1:0]  idx_q, idx_d;     // its register index
   logic [1:0]  be_q, be_d;       // its byte enables
   logic [15:0] wd_q, wd_d;       // its write data
   logic [31:0] rd_q, rd_d;       // avalon read data
   logic        wait_q, wait_d;   // avalon waitrequest

   // ----------------------------------------------------------------
   // sequencer: own registers answer in one cycle, terminal ones on ack
   // ----------------------------------------------------------------
   always_comb begin
      st_d   = st_q;
      hold_d = hold_q;
      req_d  = req_q;
      wr_d   = wr_q;
      idx_d  = idx_q;
      be_d   = be_q;
      wd_d   = wd_q;
      rd_d   = rd_q;
      wait_d = 1'b1;
      case (st_q)
         H_IDLE: begin
            if (avs_read || avs_write) begin
               if (avs_address <= AV_DEV_TOP && avs_address[1:0] == 2'h0) begin
                  st_d  = H_DEV;
                  req_d = 1'b1;
                  wr_d  = avs_write;
                  idx_d = avs_address[3:2];
                  be_d  = avs_byteenable[1:0];
                  wd_d  = avs_writedata[15:0];
               end else begin
                  st_d   = H_ACK;
                  wait_d = 1'b0;
                  rd_d   = 32'h0000_0000;
                  if (avs_address == AV_CTRL_ADDR) begin
                     rd_d = {31'h0000_0000, hold_q};
                     if (avs_write && avs_byteenable[0]) begin
                        hold_d = avs_writedata[0];
                     end
                  end else if (avs_address == AV_STAT_ADDR) begin
                     rd_d = {29'h0000_0000, link.dev_bcast_en, link.dev_mode};
                  end
               end
            end
         end
         H_DEV: begin
            if (link.app_ack) begin
               req_d  = 1'b0;
               st_d   = H_ACK;
               wait_d = 1'b0;
               rd_d   = {16'h0000, link.app_rdata};
            end
         end
         H_ACK: begin
            st_d = H_IDLE;
         end
         default: begin
            st_d = H_IDLE;
         end
      endcase
   end

   // register the sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q   <= H_IDLE;
         hold_q <= CTRL_RST;
         req_q  <= 1'b0;
         wr_q   <= 1'b0;
         idx_q  <= 2'h0;
         be_q   <= 2'h0;
         wd_q   <= 16'h0000;
         rd_q   <= 32'h0000_0000;
         wait_q <= 1'b1;
      end else begin
         st_q   <= st_d;
         hold_q <= hold_d;
         req_q  <= req_d;
         wr_q   <= wr_d;
         idx_q  <= idx_d;
         be_q   <= be_d;
         wd_q   <= wd_d;
         rd_q   <= rd_d;
         wait_q <= wait_d;
      end
   end

   // outputs from flops
   assign avs_readdata        = rd_q;
   assign avs_waitrequest     = wait_q;
   assign link.host_init_hold = hold_q;
   assign link.app_req        = req_q;
   assign link.app_wr         = wr_q;
   assign link.app_addr       = idx_q;
   assign link.app_be         = be_q;
   assign link.app_wdata      = wd_q;
endmodule

//--- rt_cfg_if.sv
// link between the host bridge and the terminal mode and config controller
`timescale 1ns/100ps
interface rt_cfg_if;
   import rt_cfg_pkg::*;
   logic        host_init_hold; // host holds terminal in initialization
   logic        app_req;        // host register request, held until ack
   logic        app_wr;         // 1 write, 0 read
   logic [1:0]  app_addr;       // register index
   logic [1:0]  app_be;         // byte enables for writes
   logic [15:0] app_wdata;      // write data
   logic [15:0] app_rdata;      // read data, valid with ack
   logic        app_ack;        // one-cycle answer
   rt_mode_t    dev_mode;       // current operating state
   logic        dev_bcast_en;   // broadcast currently accepted

   modport device (
      input  host_init_hold, app_req, app_wr, app_addr, app_be, app_wdata,
      output app_rdata, app_ack, dev_mode, dev_bcast_en
   );
   modport host (
      output host_init_hold, app_req, app_wr, app_addr, app_be, app_wdata,
      input  app_rdata, app_ack, dev_mode, dev_bcast_en
   );
endinterface

//--- rt_cfg_pkg.sv
// constants, types and helpers shared by both ends of the terminal mode and config link
//
// Operation
// - three states: reset, initialization, operational
// - init input held: freeze serial bus, host served
// - initialization: no serial reply, host access nominal
// - reset state: everything reset, nobody answered
// - host uses init hold only for setup
// - rate select: 10 MHz plus 2 MHz steps
// - active-low reset clears whole terminal
// - strap inputs captured at reset release, kept
// - timeout select: 0 gives 31 us, 1 14 us
// - fail-safe select tests 800 us inhibit timeout
// - scan test select tied low normally
// - after power-up broadcast follows pin only
// - once mode register written, field overrides pin
// - board wires parity for odd address parity
// - parity failure: valid command not processed
// - four host registers at indices 0 to 3
// - load enable: first three writable via subaddress 1
// - data words 17, 18, 19 load registers 1-3
// - up to 16 words none; 17-18 partial; 19 or more all
// - load happens at descriptor write, message end
// - loading message otherwise handled as ordinary receive
package rt_cfg_pkg;

   // ----------------------------------------------------------------
   // register indices and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]  MODE_IDX       = 2'h0;     // terminal_mode_config
   localparam logic [1:0]  CLOCK_IDX      = 2'h1;     // clock_frame_config
   localparam logic [1:0]  IMASK_IDX      = 2'h2;     // interrupt_mask_config
   localparam logic [1:0]  HOSTIF_IDX     = 2'h3;     // host_interface_config
   localparam logic [15:0] MODE_RST       = 16'h0005; // wrap and broadcast bits set
   localparam logic [15:0] CLOCK_RST      = 16'h0000;
   localparam logic [15:0] IMASK_RST      = 16'h0001; // end-of-message enabled
   localparam logic [15:0] HOSTIF_RST     = 16'h0000;
   localparam int          BCAST_FIELD    = 0;        // broadcast_allow_field position

   // ----------------------------------------------------------------
   // serial bus constants
   // ----------------------------------------------------------------
   localparam logic [4:0]  BCAST_ADDR     = 5'h1F;    // broadcast terminal address
   localparam logic [4:0]  LOAD_SUBADDR   = 5'h01;    // dynamic load subaddress
   localparam logic [5:0]  FIRST_LOAD_WORD = 6'h11;   // data word 17

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int          BASE_MHZ       = 10;
   localparam int          STEP_MHZ       = 2;
   localparam int          REPLY_LONG_US  = 31;
   localparam int          REPLY_SHORT_US = 14;
   localparam int          FAILSAFE_US    = 800;

   // ----------------------------------------------------------------
   // host side avalon map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [4:0]  AV_DEV_TOP     = 5'h0C;    // device regs at 4 x index
   localparam logic [4:0]  AV_CTRL_ADDR   = 5'h10;    // bit0 host_init_hold
   localparam logic [4:0]  AV_STAT_ADDR   = 5'h14;    // mode and broadcast state
   localparam logic        CTRL_RST       = 1'b1;     // host starts in init hold

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_INIT  = 2'b01,
      ST_OPER  = 2'b11
   } rt_mode_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_DEV  = 2'b01,
      H_ACK  = 2'b11
   } host_state_t;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // clock rate in MHz from the select code
   function automatic logic [4:0] rate_mhz(input logic [2:0] sel);
      rate_mhz = 5'(BASE_MHZ + STEP_MHZ * int'(sel));
   endfunction

   // microseconds to clock cycles at the selected rate
   function automatic logic [15:0] us_to_cycles(input int us, input logic [2:0] sel);
      us_to_cycles = 16'(us * int'(rate_mhz(sel)));
   endfunction

endpackage

//--- strap_sync.sv
// three-stage synchroniser for strap pins, output moves when stages two and three agree
`timescale 1ns/100ps
module strap_sync
   import rt_cfg_pkg::*;
#(
   parameter int W = 1
) (
   // clock
   input  wire logic         clk,
   // pins and result
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   initial begin
      if (W < 1) $error("strap_sync width must be at least 1");
   end

   logic [W-1:0] s1_q, s2_q, s3_q; // pipeline, data only, no reset needed
   logic [W-1:0] level_q, level_d; // settled value

   // accept a change once the second and third stages agree
   always_comb begin
      level_d = (s2_q == s3_q) ? s3_q : level_q;
   end

   // register the pipeline
   always_ff @(posedge clk) begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
   end

   assign level = level_q;
endmodule

//--- tb_top.sv
// bench: host bridge and terminal joined by their link, driven over avalon
`timescale 1ns/100ps
module tb_top
   import rt_cfg_pkg::*;
;
   logic        clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, cmd_valid = 0, ok;
   logic        data_valid = 0, msg_end = 0, terminal_address_parity = 0, serial_enable;
   logic        broadcast_allow_pin = 0, timeout_select = 0, loop_inhibit_n = 0;
   logic        encoder_inhibit_n = 0, failsafe_test_select = 0, cq [$];
   logic        avs_waitrequest, cmd_accept, cmd_reject;
   logic [2:0]  clock_rate_select = 0;
   logic [4:0]  avs_address = 0, terminal_address = 0, cmd_address = 0, cmd_subaddr = 0, ta;
   logic [5:0]  data_index = 0;
   logic [15:0] data_word = 0, reply_timeout_cycles, failsafe_cycles, v, sh [4];
   logic [31:0] avs_writedata = 0, avs_readdata, eq [$];
   int          bad_count = 0, compares = 0;
   rt_cfg_if link ();
   always #10 clk = ~clk;
   rt_cfg_host u_rt_cfg_host (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .link);
   rt_cfg_device u_rt_cfg_device (.clk, .rst_n, .link, .clock_rate_select, .terminal_address,
      .terminal_address_parity, .broadcast_allow_pin, .timeout_select, .loop_inhibit_n,
      .encoder_inhibit_n, .failsafe_test_select, .bus_config_load_enable(1'b1),
      .scan_test_select(1'b0),
      .cmd_valid, .cmd_address, .cmd_subaddr, .cmd_transmit(1'b0),
      .data_valid, .data_index, .data_word, .msg_end, .msg_good(1'b1), .serial_enable,
      .cmd_accept, .cmd_reject, .broadcast_enable(), .failsafe_test(), .loop_off_n(),
      .encoder_off_n(), .scan_test(), .reply_timeout_cycles, .failsafe_cycles,
      .terminal_mode_config(), .clock_frame_config(), .interrupt_mask_config(),
      .host_interface_config());
   rt_cfg_asserts u_rt_cfg_asserts (.clk, .rst_n, .host_init_hold(link.host_init_hold),
      .app_req(link.app_req), .app_wr(link.app_wr), .app_addr(link.app_addr),
      .app_be(link.app_be), .app_wdata(link.app_wdata), .app_ack(link.app_ack),
      .dev_mode(link.dev_mode), .dev_bcast_en(link.dev_bcast_en));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      {avs_write, avs_read} <= 2'h0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      eq.push_back(e);
      av(1'b0, a, '0);
   endtask
   // one command word; op says whether an answer is due
   task automatic cmd(input logic [4:0] a, input logic [4:0] s, input logic e, input logic op);
      if (op) cq.push_back(e);
      {cmd_valid, cmd_address, cmd_subaddr} <= {1'b1, a, s};
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic report_and_stop;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // answers are compared against the oldest note
   always @(posedge clk) begin
      if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, eq.pop_front());
      if (cmd_accept || cmd_reject) chk(32'(cmd_accept), cq.size() ? cq.pop_front() : 'x);
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop;
   end
   initial begin
      void'($urandom(86839));
      for (int p = 0; p < 2; p++) begin
         ok = (p == 0);
         ta = 5'($urandom % 30);
         rst_n <= 1'b0;
         {terminal_address, terminal_address_parity} <= {ta, ~^ta ^ p[0]};
         clock_rate_select <= 3'($urandom);
         {timeout_select, failsafe_test_select, loop_inhibit_n, encoder_inhibit_n,
          broadcast_allow_pin} <= 5'($urandom);
         sh = '{MODE_RST, CLOCK_RST, IMASK_RST, HOSTIF_RST};
         repeat (10) @(posedge clk);
         rst_n <= 1'b1;
         repeat (3) @(posedge clk);
         chk(reply_timeout_cycles, (timeout_select ? 14 : 31) * (10 + 2 * clock_rate_select));
         chk(failsafe_cycles, 800 * (10 + 2 * clock_rate_select));
         rd(5'h14, {29'h0, broadcast_allow_pin, 2'h1});
         cmd(ta, 5'h02, 1'b0, 1'b0);
         for (int i = 0; i < 4; i++) rd(5'(4 * i), 32'(sh[i]));
         rd(5'h18, '0);
         for (int i = 1; i < 4; i++) begin
            sh[i] = 16'($urandom);
            av(1'b1, 5'(4 * i), 32'(sh[i]));
         end
         av(1'b1, 5'h10, '0);
         repeat (3) @(posedge clk);
         chk(32'(serial_enable), 32'h1);
         rd(5'h14, {29'h0, broadcast_allow_pin, 2'h3});
         cmd(5'h1F, 5'h02, ok & broadcast_allow_pin, 1'b1);
         cmd(ta ^ 5'h01, 5'h02, 1'b0, 1'b1);
         sh[0] = 16'h0004;
         av(1'b1, 5'h00, 32'h4);
         cmd(5'h1F, 5'h02, 1'b0, 1'b1);
         cmd(ta, LOAD_SUBADDR, ok, 1'b1);
         for (int i = 1; i < 19; i++) begin
            v = 16'($urandom);
            if (ok && i > 16) sh[i - 17] = v;
            {data_valid, data_index, data_word} <= {1'b1, 6'(i), v};
            @(posedge clk);
         end
         {data_valid, msg_end} <= 2'h1;
         @(posedge clk);
         msg_end <= 1'b0;
         for (int i = 0; i < 4; i++) rd(5'(4 * i), 32'(sh[i]));
      end
      report_and_stop;
   end
endmodule
